// ===== src/period_match_timer_8bit.sv
// 8-bit period match timer with axi4-lite register access
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "period_timer_consts.svh"

module period_match_timer_8bit (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // timer outputs
  output period_timer_pkg::match_out_t match_out,
  output logic             irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0]                   timer_count;
  logic [7:0]                   period_value;
  period_timer_pkg::control_t   timer_control;
  logic                         match_irq_flag;
  logic                         match_irq_enable;
  logic [1:0]                   instr_div;
  logic [3:0]                   pre_cnt;
  logic [3:0]                   post_cnt;
  logic                         match_q;
  logic                         aw_held;
  logic                         w_held;
  logic [7:0]                   aw_addr;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic                         do_write;
  logic                         wr_count;
  logic                         wr_period;
  logic                         wr_control;
  logic                         wr_status;
  logic                         wr_mask;
  logic                         instr_tick;
  logic                         pre_tick;
  logic                         match;
  logic                         post_done;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == `OFS_COUNT) || (a == `OFS_PERIOD) ||
                 (a == `OFS_CONTROL) || (a == `OFS_STATUS) ||
                 (a == `OFS_MASK);
  endfunction

  function automatic logic [3:0] pre_limit(input logic [1:0] sel);
    if (sel[1]) begin
      pre_limit = 4'hf;
    end else if (sel[0]) begin
      pre_limit = 4'h3;
    end else begin
      pre_limit = 4'h0;
    end
  endfunction

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= period_timer_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= known_addr(aw_addr) ? period_timer_pkg::RESP_OKAY
                                          : period_timer_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only byte lane 0 carries register data
  assign wr_count   = do_write && w_strb[0] && aw_addr == `OFS_COUNT;
  assign wr_period  = do_write && w_strb[0] && aw_addr == `OFS_PERIOD;
  assign wr_control = do_write && w_strb[0] && aw_addr == `OFS_CONTROL;
  assign wr_status  = do_write && w_strb[0] && aw_addr == `OFS_STATUS;
  assign wr_mask    = do_write && w_strb[0] && aw_addr == `OFS_MASK;

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= period_timer_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= known_addr(s_axi_araddr)
                      ? period_timer_pkg::RESP_OKAY
                      : period_timer_pkg::RESP_SLVERR;
      unique case (s_axi_araddr)
        `OFS_COUNT:   s_axi_rdata <= {24'h000000, timer_count}; // R08
        `OFS_PERIOD:  s_axi_rdata <= {24'h000000, period_value}; // R08
        // top bit unimplemented, reads zero
        `OFS_CONTROL: s_axi_rdata <= {25'h0000000, timer_control}; // R10
        `OFS_STATUS:  s_axi_rdata <= {31'h00000000, match_irq_flag};
        `OFS_MASK:    s_axi_rdata <= {31'h00000000, match_irq_enable};
        default:      s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control and period registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control <= 7'(`RST_CONTROL);
    end else if (wr_control) begin
      timer_control <= 7'(w_data[7:0] & `CTRL_MASK);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_value <= `RST_PERIOD; // R05
    end else if (wr_period) begin
      period_value <= w_data[7:0]; // R08
    end
  end

  // ----------------------------------------------------------------
  // instruction clock and prescaler
  // ----------------------------------------------------------------
  // fixed divide by four from the system clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_div <= 2'b00;
    end else begin
      instr_div <= instr_div + 2'b01; // R01
    end
  end
  assign instr_tick = (instr_div == 2'(`INSTR_DIV - 1));

  assign pre_tick = instr_tick && timer_control.timer_run &&
                    pre_cnt == pre_limit(timer_control.prescale_select);

  always_ff @(posedge aclk) begin
    if (!aresetn || wr_count || wr_control) begin
      pre_cnt <= 4'h0; // R06
    end else if (instr_tick && timer_control.timer_run) begin
      pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1; // R02
    end
  end
  // stopped: no tick, counters hold R15

  // ----------------------------------------------------------------
  // count, match and postscaler
  // ----------------------------------------------------------------
  assign match = (timer_count == period_value); // R03

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count <= `RST_COUNT; // R05
    end else if (wr_count) begin
      timer_count <= w_data[7:0]; // R08
    end else if (pre_tick) begin
      // control write does not touch the count R07
      timer_count <= match ? 8'h00 : timer_count + 8'h01; // R01 R04
    end
  end

  // one pulse per match event, on the increment that restarts count
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_q <= 1'b0;
    end else begin
      match_q <= pre_tick && match && !wr_count; // R04
    end
  end

  assign match_out.pwm_time_base = match_q; // R13
  assign match_out.shift_clock   = match_q; // R14

  assign post_done = match_q &&
                     post_cnt == timer_control.postscale_select; // R09

  always_ff @(posedge aclk) begin
    if (!aresetn || wr_count || wr_control) begin
      post_cnt <= 4'h0; // R06
    end else if (match_q) begin
      post_cnt <= post_done ? 4'h0 : post_cnt + 4'h1; // R04
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  // set wins over a write-one clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_irq_flag <= 1'b0;
    end else if (post_done) begin
      match_irq_flag <= 1'b1; // R11
    end else if (wr_status && w_data[0]) begin
      match_irq_flag <= 1'b0; // R15
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_irq_enable <= 1'b0;
    end else if (wr_mask) begin
      match_irq_enable <= w_data[0];
    end
  end

  assign irq = match_irq_flag && match_irq_enable; // R12

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_period_reset;
    @(posedge aclk) $rose(aresetn) |-> period_value == `RST_PERIOD;
  endproperty
  a_period_reset: assert property (p_period_reset) // R05
    else $error("period not all ones after reset");

  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
      pre_tick && match && !wr_count |=> timer_count == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) // R04
    else $error("count did not restart after match");

  property p_incr;
    @(posedge aclk) disable iff (!aresetn)
      pre_tick && !match && !wr_count |=>
        timer_count == $past(timer_count) + 8'h01;
  endproperty
  a_incr: assert property (p_incr) // R01
    else $error("count did not advance");

  property p_ctrl_keeps_count;
    @(posedge aclk) disable iff (!aresetn)
      wr_control && !pre_tick && !wr_count |=> $stable(timer_count);
  endproperty
  a_ctrl_keeps_count: assert property (p_ctrl_keeps_count) // R07
    else $error("control write changed count");

  property p_scalers_clear;
    @(posedge aclk) disable iff (!aresetn)
      wr_count || wr_control |=> pre_cnt == 4'h0 && post_cnt == 4'h0;
  endproperty
  a_scalers_clear: assert property (p_scalers_clear) // R06
    else $error("scalers not cleared by write");

  property p_stopped_hold;
    @(posedge aclk) disable iff (!aresetn)
      // a match pulse launched by the stopping write still lands once
      !timer_control.timer_run && !match_q && !wr_count && !wr_control |=>
        $stable(timer_count) && $stable(pre_cnt) && $stable(post_cnt);
  endproperty
  a_stopped_hold: assert property (p_stopped_hold) // R15
    else $error("stopped timer moved");

  property p_flag_set;
    @(posedge aclk) disable iff (!aresetn)
      post_done |=> match_irq_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) // R11
    else $error("flag not latched at postscale end");

  property p_irq_gate;
    @(posedge aclk) disable iff (!aresetn)
      irq == (match_irq_flag && match_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // R12
    else $error("interrupt not gated by enable");

  property p_prescale16;
    @(posedge aclk) disable iff (!aresetn)
      pre_tick && timer_control.prescale_select[1] |->
        $past(pre_cnt, 4) == 4'he;
  endproperty
  a_prescale16: assert property (p_prescale16) // R02
    else $error("divide by 16 tick misplaced");

endmodule
`default_nettype wire

// ===== src/period_timer_consts.svh
// constants for the 8-bit period match timer
// Overview of operation
// [R01] count up from zero each prescaled instruction clock
// [R02] prescaler divides by 1, 4 or 16
// [R03] match raised when count equals period
// [R04] count restarts after match; match clocks postscaler
// [R05] reset clears count, period becomes all ones
// [R06] count or control write clears both scalers
// [R07] control write leaves count unchanged
// [R08] count and period readable and writable anytime
// [R09] postscale ratio is field value plus one
// [R10] bit 2 runs timer; bit 7 reads zero
// [R11] postscaler terminal count latches match flag
// [R12] flag requests interrupt only while enabled
// [R13] unscaled match exported as pwm time base
// [R14] match offered as serial port shift clock
// [R15] flag sticky; stopped timer holds all counters
`ifndef PERIOD_TIMER_CONSTS_SVH
`define PERIOD_TIMER_CONSTS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_COUNT      8'h00
`define OFS_PERIOD     8'h04
`define OFS_CONTROL    8'h08
`define OFS_STATUS     8'h0c
`define OFS_MASK       8'h10

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CTRL_RUN_BIT   2
`define CTRL_PS_LSB    0
`define CTRL_POST_LSB  3
`define CTRL_MASK      8'h7f
`define RST_COUNT      8'h00
`define RST_PERIOD     8'hff
`define RST_CONTROL    8'h00
`define INSTR_DIV      4

`endif

// ===== src/period_timer_pkg.sv
// types for the 8-bit period match timer
package period_timer_pkg;

  typedef struct packed {
    logic [3:0] postscale_select;
    logic       timer_run;
    logic [1:0] prescale_select;
  } control_t;

  typedef struct packed {
    logic pwm_time_base;
    logic shift_clock;
  } match_out_t;

  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } resp_t;

endpackage

// ===== test/period_match_timer_8bit_bench.sv
// self-checking bench for the 8-bit period match timer
`timescale 1ns/1ps
`default_nettype none
`include "period_timer_consts.svh"
module period_match_timer_8bit_bench;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [1:0] OK_R = period_timer_pkg::RESP_OKAY;
  localparam logic [1:0] ER_R = period_timer_pkg::RESP_SLVERR;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  period_timer_pkg::match_out_t mo;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;
  int          sc_bad = 0;
  logic [31:0] seed = 32'h1ecfba61;

  always #10 aclk = ~aclk;

  period_match_timer_8bit dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .match_out(mo), .irq(irq)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic int divof(input logic [1:0] p);
    return (p == 2'b00) ? 1 : ((p == 2'b01) ? 4 : 16);
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ready and valid are sampled mid-cycle: they only move at rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok, aw_now, w_now, b_now;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      aw_now = !aw_ok && awready;
      w_now = !w_ok && wready;
      @(posedge aclk);
      if (aw_now) awvalid <= 1'b0;
      if (w_now) wvalid <= 1'b0;
      aw_ok = aw_ok | aw_now;
      w_ok = w_ok | w_now;
    end
    do begin
      @(negedge aclk);
      b_now = bvalid;
      if (b_now)
        chk("bresp", 32'(bresp), 32'((a > `OFS_MASK) ? ER_R : OK_R));
      @(posedge aclk);
    end while (!b_now);
    bready <= 1'b0;
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    logic ar_now, r_now;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_now = arready;
      @(posedge aclk);
    end while (!ar_now);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      r_now = rvalid;
      if (r_now) chk(nm, rdata, e);
      if (r_now) chk("rresp", 32'(rresp), 32'((a > `OFS_MASK) ? ER_R : OK_R));
      @(posedge aclk);
    end while (!r_now);
    rready <= 1'b0;
  endtask

  // cycles up to and including the next match pulse
  task automatic gap(output int c);
    c = 0;
    do begin
      @(negedge aclk);
      c++;
      if (mo.shift_clock !== mo.pwm_time_base) sc_bad++;
    end while (mo.pwm_time_base !== 1'b1 && c < 5000);
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int c, c1, per, n;
    logic [3:0] ps;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rc("count", `OFS_COUNT, 32'h0);
    rc("period", `OFS_PERIOD, 32'hff);
    rc("control", `OFS_CONTROL, 32'h0);
    rc("status", `OFS_STATUS, 32'h0);
    chk("irq_reset", 32'(irq), 32'h0);
    wr(`OFS_PERIOD, 32'hffffff5a);
    rc("period", `OFS_PERIOD, 32'h5a);
    // lane 0 strobe low: the write must be dropped
    wstrb <= 4'he;
    wr(`OFS_PERIOD, 32'h11);
    wstrb <= 4'hf;
    rc("period_strobe", `OFS_PERIOD, 32'h5a);
    wr(`OFS_COUNT, 32'h33);
    rc("count", `OFS_COUNT, 32'h33);
    wr(`OFS_CONTROL, 32'hfb);
    rc("control", `OFS_CONTROL, 32'h7b);
    wr(8'h14, 32'h1);
    rc("unmapped", 8'h14, 32'h0);
    $display("register test done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      per = (i == 0) ? 0 : int'(seed[4:0]);
      wr(`OFS_PERIOD, 32'(per));
      wr(`OFS_CONTROL, {29'h0, 1'b1, 2'(i)});
      // count written last so it never starts above the new period
      wr(`OFS_COUNT, 32'h0);
      gap(c);
      gap(c);
      chk("interval", 32'(c), 32'(4 * divof(2'(i)) * (per + 1)));
      $display("prescale test %0d done", i);
    end
    chk("shift_clock", 32'(sc_bad), 32'h0);
    wr(`OFS_PERIOD, 32'h7);
    wr(`OFS_MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      ps = (i == 0) ? 4'hf : ((i == 1) ? 4'h3 : ((i == 2) ? 4'h0 : seed[3:0]));
      wr(`OFS_CONTROL, {25'h0, ps, 3'b100});
      wr(`OFS_COUNT, 32'h0);
      wr(`OFS_STATUS, 32'h1);
      n = 0;
      for (int t = 0; t < 3000; t++) begin
        @(negedge aclk);
        if (irq === 1'b1) break;
        if (mo.pwm_time_base === 1'b1) n++;
      end
      chk("pulses", 32'(n), 32'(ps) + 32'h1);
      chk("irq_on", 32'(irq), 32'h1);
      wr(`OFS_MASK, 32'h0);
      @(negedge aclk);
      chk("irq_masked", 32'(irq), 32'h0);
      rc("flag_sticky", `OFS_STATUS, 32'h1);
      wr(`OFS_MASK, 32'h1);
      $display("postscale test %0d done", ps);
    end
    // stop first so no postscale end can race the clear
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_STATUS, 32'h1);
    rc("flag_clear", `OFS_STATUS, 32'h0);
    seed = lfsr(seed);
    c1 = int'(seed[7:0]);
    wr(`OFS_COUNT, 32'(c1));
    rc("count_stop", `OFS_COUNT, 32'(c1));
    wr(`OFS_CONTROL, 32'h78);
    rc("count_ctrl_wr", `OFS_COUNT, 32'(c1));
    repeat (100) @(posedge aclk);
    rc("count_hold", `OFS_COUNT, 32'(c1));
    $display("stop test done");
    give_verdict();
  end
endmodule
`default_nettype wire
